// ---- design/scuf_map.vh ----
`ifndef SCUF_MAP_VH
`define SCUF_MAP_VH

// Register indices; the byte address is four times the index.
`define SCUF_IDX_STATUS      6'h0e
`define SCUF_IDX_CONFIG      6'h0f

// Reset values.
`define SCUF_STATUS_RESET    8'h00
`define SCUF_CONFIG_RESET    7'h00

// Status register bit positions.
`define SCUF_ST_TO3          7
`define SCUF_ST_TO2          6
`define SCUF_ST_TO1          5
`define SCUF_ST_EA           4
`define SCUF_ST_PE           3
`define SCUF_ST_OVR          2
`define SCUF_ST_FER          1
`define SCUF_ST_BUF          0

// Configuration register bit positions.
`define SCUF_CFG_DIR_TX      0
`define SCUF_CFG_PROTO_T1    1
`define SCUF_CFG_LCT         2
`define SCUF_CFG_BUF_MASK    3
`define SCUF_CFG_PEC_LO      4
`define SCUF_CFG_PEC_HI      6

// Timing.
`define SCUF_CLK_PERIOD_NS   100
`define SCUF_READ_CLEAR_NS   2000
`define SCUF_READ_CLEAR_CYC  5'd20
`define SCUF_BUF_CLEAR_CYC   3
`define SCUF_EA_IGNORE_CLKS  9'd200
`define SCUF_EA_MAX_CLKS     9'd368

`endif

// ---- design/scuf_sync2.v ----
`timescale 1ns/1ps
`default_nettype none

module scuf_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // Two flops bring pin levels into the clock domain.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // scuf_sync2

`default_nettype wire

// ---- design/scuf_top.v ----
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "scuf_map.vh"

module scuf_top (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        IO_IN,
  input  wire        CARD_RST,
  input  wire        CARD_CLK,
  input  wire [2:0]  TIMEOUT_TC,
  input  wire        RX_PARITY_POINT,
  input  wire        RX_PARITY_BAD,
  input  wire        TX_PARITY_POINT,
  input  wire        TX_NAK,
  input  wire        FRAME_POINT,
  input  wire        FIFO_FULL,
  input  wire        TX_LOAD_OK,
  input  wire        TX_HOLD_WR,
  input  wire        RX_HOLD_RD,
  input  wire        AUTO_RX_SWITCH,
  output reg         IRQ_LINE_N,
  output reg         RX_STORE,
  output reg         DIR_TX,
  output reg         LAST_CHAR_MODE
);

  localparam [4:0] RCLR_LOAD = `SCUF_READ_CLEAR_CYC - 5'd1;

  // Synchronised pin levels.
  wire [2:0] pin_sync;
  wire       io_s;
  wire       rst_s;
  wire       cclk_s;

  scuf_sync2 #(
    .W (3)
  ) u_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .din    ({CARD_CLK, CARD_RST, ~IO_IN}),
    .dout   (pin_sync)
  );

  // The I/O level travels inverted so that the synchroniser's reset value matches a released line.
  assign io_s   = ~pin_sync[0];
  assign rst_s  = pin_sync[1];
  assign cclk_s = pin_sync[2];

  reg  [7:0] status_q;
  reg  [7:0] status_d;
  reg  [6:0] cfg_q;
  reg  [6:0] cfg_d;
  reg  [6:0] rd_mask_q;
  reg  [6:0] rd_mask_d;
  reg  [4:0] rclr_cnt_q;
  reg  [4:0] rclr_cnt_d;
  reg        rclr_pend_q;
  reg        rclr_pend_d;
  reg  [`SCUF_BUF_CLEAR_CYC-1:0] buf_pipe_q;
  reg        fifo_full_prev_q;
  reg  [2:0] pe_cnt_q;
  reg  [2:0] pe_cnt_d;
  reg        io_prev_q;
  reg        rst_prev_q;
  reg        cclk_prev_q;
  reg  [8:0] cclk_cnt_q;
  reg  [8:0] cclk_cnt_d;
  reg        start_seen_q;
  reg        start_seen_d;
  reg  [7:0] set_v;
  reg  [7:0] clr_v;
  reg        ea_set;

  wire       acc_done;
  wire       hit_status;
  wire       hit_config;
  wire       pready_d;
  wire       io_fall;
  wire       rst_toggle;
  wire       cclk_rise;
  wire       t1_mode;
  wire [2:0] pec;
  wire       rx_bad_t0;
  wire       tx_nak_t0;
  wire       pe_limit;
  wire       irq_d;

  // Register bus decode.
  assign hit_status = (PADDR[7:2] == `SCUF_IDX_STATUS);
  assign hit_config = (PADDR[7:2] == `SCUF_IDX_CONFIG);
  assign pready_d   = PSEL & PENABLE & ~PREADY;
  assign acc_done   = PSEL & PENABLE & PREADY;

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= pready_d;
      PSLVERR <= pready_d & ~hit_status & ~hit_config;
      if (pready_d & ~PWRITE & hit_status) begin
        PRDATA <= {24'h00_0000, status_q};
      end else if (pready_d & ~PWRITE & hit_config) begin
        PRDATA <= {25'h000_0000, cfg_q};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // Configuration; a completed write wins over the automatic direction clear.
  always @* begin
    cfg_d = cfg_q;
    if (AUTO_RX_SWITCH) begin
      cfg_d[`SCUF_CFG_DIR_TX] = 1'b0;
    end
    if (acc_done & PWRITE & hit_config) begin
      cfg_d = PWDATA[6:0];
    end
  end

  assign t1_mode = cfg_q[`SCUF_CFG_PROTO_T1];
  assign pec     = cfg_q[`SCUF_CFG_PEC_HI:`SCUF_CFG_PEC_LO];

  // Delayed clear of the flags other than the buffer flag that a status read returned.
  always @* begin
    rd_mask_d   = rd_mask_q;
    rclr_cnt_d  = rclr_cnt_q;
    rclr_pend_d = rclr_pend_q;
    if (rclr_pend_q && rclr_cnt_q == 5'h00) begin
      rclr_pend_d = 1'b0;
      rd_mask_d   = 7'h00;
    end else if (rclr_pend_q) begin
      rclr_cnt_d = rclr_cnt_q - 5'h01;
    end
    if (acc_done & ~PWRITE & hit_status) begin
      rd_mask_d   = (rclr_pend_q && rclr_cnt_q != 5'h00) ? (rd_mask_q | PRDATA[7:1]) : PRDATA[7:1];
      rclr_cnt_d  = RCLR_LOAD;
      rclr_pend_d = 1'b1;
    end
  end

  // Parity error counting.
  assign rx_bad_t0 = RX_PARITY_POINT & RX_PARITY_BAD & ~t1_mode;
  assign tx_nak_t0 = TX_PARITY_POINT & TX_NAK & ~t1_mode;
  assign pe_limit  = (pe_cnt_q == pec);

  always @* begin
    pe_cnt_d = pe_cnt_q;
    if (t1_mode) begin
      pe_cnt_d = 3'h0;
    end else if (rx_bad_t0 | tx_nak_t0) begin
      pe_cnt_d = pe_limit ? 3'h0 : pe_cnt_q + 3'h1;
    end else if ((RX_PARITY_POINT & ~RX_PARITY_BAD) | (TX_PARITY_POINT & ~TX_NAK)) begin
      pe_cnt_d = 3'h0;
    end
  end

  // Early-answer watch on card clocks since the last reset toggle.
  assign io_fall    = io_prev_q & ~io_s;
  assign rst_toggle = rst_prev_q ^ rst_s;
  assign cclk_rise  = ~cclk_prev_q & cclk_s;

  always @* begin
    cclk_cnt_d   = cclk_cnt_q;
    start_seen_d = start_seen_q;
    ea_set       = 1'b0;
    if (cclk_rise && cclk_cnt_q < `SCUF_EA_MAX_CLKS) begin
      cclk_cnt_d = cclk_cnt_q + 9'h001;
    end
    if (io_fall && !start_seen_q) begin
      if (rst_s) begin
        start_seen_d = 1'b1;
        ea_set       = (cclk_cnt_q < `SCUF_EA_MAX_CLKS);
      end else if (cclk_cnt_q >= `SCUF_EA_IGNORE_CLKS) begin
        start_seen_d = 1'b1;
        ea_set       = (cclk_cnt_q < `SCUF_EA_MAX_CLKS);
      end
    end
    if (rst_toggle) begin
      cclk_cnt_d   = 9'h000;
      start_seen_d = 1'b0;
    end
  end

  // Flag set and clear terms; a set wins over a clear in the same cycle.
  always @* begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[`SCUF_ST_TO1] = TIMEOUT_TC[0];
    set_v[`SCUF_ST_TO2] = TIMEOUT_TC[1];
    set_v[`SCUF_ST_TO3] = TIMEOUT_TC[2];
    set_v[`SCUF_ST_EA]  = ea_set;
    set_v[`SCUF_ST_PE]  = ((rx_bad_t0 | tx_nak_t0) & pe_limit)
                        | (t1_mode & RX_PARITY_POINT & RX_PARITY_BAD)
                        | (t1_mode & TX_PARITY_POINT & TX_NAK);
    set_v[`SCUF_ST_OVR] = RX_PARITY_POINT & FIFO_FULL;
    set_v[`SCUF_ST_FER] = FRAME_POINT & ~io_s;
    if (cfg_q[`SCUF_CFG_DIR_TX]) begin
      set_v[`SCUF_ST_BUF] = TX_LOAD_OK & ~cfg_q[`SCUF_CFG_LCT];
    end else begin
      set_v[`SCUF_ST_BUF] = FIFO_FULL & ~fifo_full_prev_q;
    end
    if (rclr_pend_q && rclr_cnt_q == 5'h00) begin
      clr_v[7:1] = rd_mask_q;
    end
    clr_v[`SCUF_ST_BUF] = buf_pipe_q[`SCUF_BUF_CLEAR_CYC-1]
                        | (cfg_q[`SCUF_CFG_DIR_TX] & ~cfg_d[`SCUF_CFG_DIR_TX]);
    status_d = (status_q & ~clr_v) | set_v;
  end

  assign irq_d = (|status_d[7:1])
               | (status_d[`SCUF_ST_BUF] & ~cfg_d[`SCUF_CFG_BUF_MASK]);

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_q         <= `SCUF_STATUS_RESET;
      cfg_q            <= `SCUF_CONFIG_RESET;
      rd_mask_q        <= 7'h00;
      rclr_cnt_q       <= 5'h00;
      rclr_pend_q      <= 1'b0;
      buf_pipe_q       <= {`SCUF_BUF_CLEAR_CYC{1'b0}};
      fifo_full_prev_q <= 1'b0;
      pe_cnt_q         <= 3'h0;
      io_prev_q        <= 1'b1;
      rst_prev_q       <= 1'b0;
      cclk_prev_q      <= 1'b0;
      cclk_cnt_q       <= 9'h000;
      start_seen_q     <= 1'b0;
      IRQ_LINE_N       <= 1'b1;
      RX_STORE         <= 1'b0;
      DIR_TX           <= 1'b0;
      LAST_CHAR_MODE   <= 1'b0;
    end else begin
      status_q         <= status_d;
      cfg_q            <= cfg_d;
      rd_mask_q        <= rd_mask_d;
      rclr_cnt_q       <= rclr_cnt_d;
      rclr_pend_q      <= rclr_pend_d;
      buf_pipe_q       <= {buf_pipe_q[`SCUF_BUF_CLEAR_CYC-2:0], TX_HOLD_WR | RX_HOLD_RD};
      fifo_full_prev_q <= FIFO_FULL;
      pe_cnt_q         <= pe_cnt_d;
      io_prev_q        <= io_s;
      rst_prev_q       <= rst_s;
      cclk_prev_q      <= cclk_s;
      cclk_cnt_q       <= cclk_cnt_d;
      start_seen_q     <= start_seen_d;
      IRQ_LINE_N       <= ~irq_d;
      RX_STORE         <= RX_PARITY_POINT & (t1_mode | ~RX_PARITY_BAD);
      DIR_TX           <= cfg_d[`SCUF_CFG_DIR_TX];
      LAST_CHAR_MODE   <= cfg_d[`SCUF_CFG_LCT];
    end
  end

endmodule // scuf_top

`default_nettype wire

// ---- tb/scuf_card.sv ----
`timescale 1ns/1ps
`default_nettype none
module scuf_card (
  input  wire logic       card_clk,
  input  wire logic       card_rst,
  input  wire logic [9:0] delay,
  output logic            io
);
  logic [9:0] n;
  logic       r;
  initial begin
    n = 10'h0;
    r = 1'b0;
    io = 1'b1;
  end
  // Sends a start bit a set number of card clocks after each reset toggle; the released line reads high.
  always @(posedge card_clk) begin
    if (card_rst != r) n <= 10'h1;
    else if (n != 10'h0 && n != 10'h3ff) n <= n + 10'h1;
    r <= card_rst;
    io <= !(n >= delay && n < delay + 10'h8);
  end
endmodule // scuf_card
`default_nettype wire

// ---- tb/scuf_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scuf_map.vh"
module scuf_top_checker (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [2:0]  TIMEOUT_TC,
  input wire logic        RX_PARITY_POINT,
  input wire logic        RX_PARITY_BAD,
  input wire logic        TX_PARITY_POINT,
  input wire logic        FRAME_POINT,
  input wire logic        FIFO_FULL,
  input wire logic        TX_LOAD_OK,
  input wire logic        IRQ_LINE_N,
  input wire logic        RX_STORE
);
  logic [4:0] cnt_q;
  logic       shown_q;
  logic       t1_q;
  wire        done = PSEL && PENABLE && PREADY;
  wire        rd_st = done && !PWRITE && PADDR[7:2] == `SCUF_IDX_STATUS;
  wire        ev = |TIMEOUT_TC || RX_PARITY_POINT || TX_PARITY_POINT || FRAME_POINT || FIFO_FULL || TX_LOAD_OK;
  // Counts cycles since a status read that left the buffer flag clear, with no flag event since.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= 5'h0;
      shown_q <= 1'b0;
      t1_q <= 1'b0;
    end else begin
      if (ev) cnt_q <= 5'h0;
      else if (rd_st) cnt_q <= {4'h0, !PRDATA[0]};
      else if (cnt_q != 5'h0 && cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h1;
      if (rd_st) shown_q <= |PRDATA[7:1];
      if (done && PWRITE && PADDR[7:2] == `SCUF_IDX_CONFIG) t1_q <= PWDATA[1];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_rx(bad);
    RX_PARITY_POINT && !FIFO_FULL && bad;
  endsequence
  chk_ready_wait: assert property (s_wait |=> PREADY) else $error("no ready");
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
  chk_err_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("bad error");
  chk_status_width: assert property (rd_st |-> PRDATA[31:8] == 24'h0) else $error("wide status");
  chk_tc_irq: assert property (|TIMEOUT_TC |=> !IRQ_LINE_N) else $error("no timeout irq");
  chk_ovr_irq: assert property (RX_PARITY_POINT && FIFO_FULL |=> !IRQ_LINE_N) else $error("no overrun");
  chk_bad_drop: assert property (s_rx(RX_PARITY_BAD && !t1_q) |=> !RX_STORE) else $error("stored");
  chk_good_keep: assert property (s_rx(!RX_PARITY_BAD || t1_q) |=> RX_STORE) else $error("dropped");
  chk_clear_wait: assert property (cnt_q == 5'h14 && shown_q |-> !IRQ_LINE_N) else $error("early clear");
  chk_clear_done: assert property (cnt_q == 5'h15 |-> IRQ_LINE_N) else $error("no clear");
endmodule // scuf_top_checker
bind scuf_top scuf_top_checker u_chk (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .PSLVERR, .TIMEOUT_TC, .RX_PARITY_POINT, .RX_PARITY_BAD, .TX_PARITY_POINT, .FRAME_POINT,
  .FIFO_FULL, .TX_LOAD_OK, .IRQ_LINE_N, .RX_STORE);
`default_nettype wire

// ---- tb/scuf_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module scuf_top_tb;
  logic        clk, resetn, psel, penable, pwrite, rx_bad, tx_nak, fifo_full, card_rst, card_clk, tb_io;
  logic        pready, pslverr, irq_n, rx_store, dir_tx, last_char_mode, card_io, er;
  logic [7:0]  paddr;
  logic [9:0]  p, delay;
  logic [31:0] pwdata, prdata, rd, seed, checks, n_mismatch, cycles;
  int          dl[6] = '{300, 250, 400, 100, 100, 400};
  scuf_top dut (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IO_IN(card_io & tb_io),
    .CARD_RST(card_rst), .CARD_CLK(card_clk), .TIMEOUT_TC(p[2:0]), .RX_PARITY_POINT(p[3]),
    .RX_PARITY_BAD(rx_bad), .TX_PARITY_POINT(p[4]), .TX_NAK(tx_nak), .FRAME_POINT(p[5]), .FIFO_FULL(fifo_full),
    .TX_LOAD_OK(p[6]), .TX_HOLD_WR(p[7]), .RX_HOLD_RD(p[8]), .AUTO_RX_SWITCH(p[9]), .IRQ_LINE_N(irq_n),
    .RX_STORE(rx_store), .DIR_TX(dir_tx), .LAST_CHAR_MODE(last_char_mode));
  scuf_card card (.card_clk(card_clk), .card_rst(card_rst), .delay(delay), .io(card_io));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    card_clk = 1'b0;
    #13 forever #400 card_clk = ~card_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic ea_exp(input logic hi, input int d);
    return hi ? d < 368 : (d >= 200 && d < 368);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task pulse(input logic [9:0] m);
    @(posedge clk);
    p <= m;
    @(posedge clk);
    p <= 10'h0;
  endtask
  task par(input int m, input logic bad);
    @(posedge clk);
    rx_bad <= bad;
    tx_nak <= bad;
    p <= m ? 10'h10 : 10'h8;
    @(posedge clk);
    p <= 10'h0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  initial begin
    {resetn, psel, penable, pwrite, rx_bad, tx_nak, fifo_full, card_rst} = 8'h0;
    {tb_io, paddr, pwdata, p, delay} = {1'b1, 8'h0, 32'h0, 10'h0, 10'h3ff};
    {seed, checks, n_mismatch, cycles} = {32'h348bab32, 96'h0};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    cyc(3);
    rdc(8'h38, 32'h0);
    apb(1'b1, 8'h38, 32'hff);
    rdc(8'h38, 32'h0);
    rdc(8'h40, 32'h0);
    chk(er, 1'b1);
    for (int i = 0; i < 3; i++) begin
      pulse(10'h1 << i);
      cyc(1);
      chk(irq_n, 1'b0);
      rdc(8'h38, 32'h20 << i);
      cyc(19);
      chk(irq_n, 1'b0);
      cyc(2);
      chk(irq_n, 1'b1);
    end
    pulse(10'h20);
    @(posedge clk) tb_io <= 1'b0;
    cyc(5);
    pulse(10'h20);
    @(posedge clk) tb_io <= 1'b1;
    rdc(8'h38, 32'h2);
    cyc(21);
    rdc(8'h38, 32'h0);
    $display("registers, time-out and framing done");
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      delay <= dl[k][9:0];
      card_rst <= !card_rst;
      cyc(3700);
      rdc(8'h38, {27'h0, ea_exp(card_rst, dl[k]), 4'h0});
      cyc(22);
    end
    $display("early answer done");
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, 8'h3c, c << 4);
        seed = xs(seed);
        for (int n = 0; n < seed % (c + 1); n++) par(m, 1'b1);
        par(m, 1'b0);
        for (int n = 0; n < c; n++) par(m, 1'b1);
        cyc(1);
        chk(irq_n, 1'b1);
        par(m, 1'b1);
        rdc(8'h38, 32'h8);
        cyc(21);
        if (m == 1) pulse(10'h80);
      end
    end
    apb(1'b1, 8'h3c, 32'h2);
    par(0, 1'b1);
    rdc(8'h38, 32'h8);
    cyc(21);
    $display("parity done");
    apb(1'b1, 8'h3c, 32'h0);
    @(posedge clk) fifo_full <= 1'b1;
    cyc(5);
    chk(irq_n, 1'b0);
    par(0, 1'b0);
    rdc(8'h38, 32'h5);
    cyc(21);
    @(posedge clk) fifo_full <= 1'b0;
    pulse(10'h100);
    cyc(2);
    chk(irq_n, 1'b0);
    cyc(1);
    chk(irq_n, 1'b1);
    apb(1'b1, 8'h3c, 32'h8);
    @(posedge clk) fifo_full <= 1'b1;
    cyc(5);
    chk(irq_n, 1'b1);
    rdc(8'h38, 32'h1);
    for (int w = 0; w < 3; w++) begin
      apb(1'b1, 8'h3c, 32'h1);
      pulse(10'h40);
      cyc(1);
      chk(irq_n, 1'b0);
      if (w == 0) pulse(10'h80);
      if (w == 1) apb(1'b1, 8'h3c, 32'h0);
      if (w == 2) pulse(10'h200);
      cyc(3);
      chk(irq_n, 1'b1);
      chk(dir_tx, w == 0);
    end
    apb(1'b1, 8'h3c, 32'h5);
    pulse(10'h40);
    cyc(2);
    chk(irq_n, 1'b1);
    chk(last_char_mode, 1'b1);
    $display("buffer flag done");
    print_verdict;
  end
endmodule // scuf_top_tb
`default_nettype wire
